// ### shared/tolr_consts.svh
// Overview of operation
// - In latch-release mode the latched shutoff state is left on an off-to-on edge of the reset source chosen by the reset-action setting.
// - The latched state is never left while either torque-off input is off, and reset edges seen then are dropped.
// - In alarm-shutdown mode the latched state is left only on a rising edge of the alarm clear input.
// - With both torque-off inputs off the monitor output is raised and motor power is removed.
// - An excitation command present while the shutoff clear input is on excites the motor in the same step as the release.
// - On a release with excitation, ready rises together with direct command ready, or with pulse command ready in pulse-input operation.
// - Both inputs off with the monitor on enters the latched state or alarm shutdown, as the mode setting selects.
// - Exactly one input off raises the emergency stop circuit error alarm and keeps the motor unexcited.
`ifndef TOLR_CONSTS_SVH
`define TOLR_CONSTS_SVH
// ==========================================
// Register map
`define TOLR_ADR_CTRL 4'h0
`define TOLR_ADR_STAT 4'h1
`define TOLR_ADR_IRQ_STAT 4'h2
`define TOLR_ADR_IRQ_CLR 4'h3
`define TOLR_ADR_IRQ_EN 4'h4
// ==========================================
// Control fields
`define TOLR_CTRL_MODE 0
`define TOLR_CTRL_SRC_LO 1
`define TOLR_CTRL_SRC_HI 2
`define TOLR_CTRL_PULSE 3
`define TOLR_CTRL_RST 4'h0
// ==========================================
// Reset source codes
`define TOLR_SRC_SHUTOFF_CLR 2'h0
`define TOLR_SRC_ALARM_CLR 2'h1
`define TOLR_SRC_AUX 2'h2
// ==========================================
// Event bits
`define TOLR_EV_LATCH 0
`define TOLR_EV_ALARM 1
`define TOLR_EV_RELEASE 2
`define TOLR_EV_DROPPED 3
`endif

// ### shared/tolr_pkg.sv
package tolr_pkg;
   typedef enum logic [2:0] {
      TOLR_RUN = 3'h1,
      TOLR_LATCHED = 3'h2,
      TOLR_ALARM = 3'h4
   } tolr_state_t;
endpackage : tolr_pkg

// ### shared/tolr_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries reset source rising edges from the edge stage to the sequencer
interface tolr_edge_if;
   logic [3:0] rise;
   modport src (output rise);
   modport dst (input rise);
endinterface : tolr_edge_if
`default_nettype wire

// ### core/tolr_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tolr_edge #(
   parameter int N = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Sources
   input wire logic [N-1:0] lvl_i,
   // Edges out
   tolr_edge_if.src e
);
   logic [N-1:0] prev_reg;
   logic [N-1:0] prev_next;
   // Only four source lanes fit the edge carrier, so refuse any other width at elaboration
   if (N != 4) begin : g_bad_n
      $error("tolr_edge needs N of 4");
   end
   // Previous sample, reset as on so a held source gives no edge
   always_comb begin
      prev_next = lvl_i;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= '1;
      end else begin
         prev_reg <= prev_next;
      end
   end
   assign e.rise = lvl_i & ~prev_reg;
endmodule : tolr_edge
`default_nettype wire

// ### core/tolr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tolr_consts.svh"
module tolr_top
   import tolr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Safety and operator inputs
   input wire logic torque_off_in_a,
   input wire logic torque_off_in_b,
   input wire logic shutoff_clear_in,
   input wire logic alarm_clear_in,
   input wire logic aux_reset_in,
   input wire logic excite_cmd_i,
   // Drive outputs
   output logic shutoff_monitor_out,
   output logic motor_power_o,
   output logic alarm_o,
   output logic ready_o,
   output logic direct_cmd_ready_out,
   output logic pulse_cmd_ready_out,
   output logic irq_o
);
   // ==========================================
   // Edge stage
   tolr_edge_if eif ();
   logic [3:0] lvl;
   assign lvl = {1'b0, aux_reset_in, alarm_clear_in, shutoff_clear_in};
   tolr_edge #(.N(4)) u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lvl_i(lvl),
      .e(eif.src)
   );
   // ==========================================
   // Sequencer state
   tolr_state_t state_reg, state_next;
   logic mon_reg, mon_next;
   logic pwr_reg, pwr_next;
   logic alm_reg, alm_next;
   logic rdy_reg, rdy_next;
   logic drdy_reg, drdy_next;
   logic prdy_reg, prdy_next;
   logic [3:0] ctrl_reg;
   logic [3:0] ev;
   logic both_off, one_off, both_on, src_edge, rel_edge;
   always_comb begin
      both_off = ~torque_off_in_a & ~torque_off_in_b;
      one_off = torque_off_in_a ^ torque_off_in_b;
      both_on = torque_off_in_a & torque_off_in_b;
      case (ctrl_reg[`TOLR_CTRL_SRC_HI:`TOLR_CTRL_SRC_LO])
         `TOLR_SRC_SHUTOFF_CLR: src_edge = eif.rise[`TOLR_SRC_SHUTOFF_CLR];
         `TOLR_SRC_ALARM_CLR: src_edge = eif.rise[`TOLR_SRC_ALARM_CLR];
         `TOLR_SRC_AUX: src_edge = eif.rise[`TOLR_SRC_AUX];
         default: src_edge = 1'b0;
      endcase
      // Alarm-shutdown releases only from the alarm clear edge
      rel_edge = ctrl_reg[`TOLR_CTRL_MODE] ? eif.rise[`TOLR_SRC_ALARM_CLR] : src_edge;
   end
   // Next state; latching has priority over any release in the same cycle
   always_comb begin
      state_next = state_reg;
      ev = 4'h0;
      case (state_reg)
         TOLR_RUN: begin
            if (both_off) begin
               state_next = ctrl_reg[`TOLR_CTRL_MODE] ? TOLR_ALARM : TOLR_LATCHED;
               ev[`TOLR_EV_LATCH] = 1'b1;
            end else if (one_off) begin
               ev[`TOLR_EV_ALARM] = ~alm_reg;
            end
         end
         TOLR_LATCHED, TOLR_ALARM: begin
            if (rel_edge && both_on && !alm_reg) begin
               state_next = TOLR_RUN;
               ev[`TOLR_EV_RELEASE] = 1'b1;
            end else if (rel_edge) begin
               ev[`TOLR_EV_DROPPED] = 1'b1;
            end
         end
         default: state_next = TOLR_LATCHED;
      endcase
   end
   // Outputs follow the next state so they move in the release step
   always_comb begin
      mon_next = both_off || (state_next != TOLR_RUN);
      // Circuit alarm held until cleared with both inputs on
      alm_next = (alm_reg | one_off) & ~(eif.rise[`TOLR_SRC_ALARM_CLR] & both_on);
      pwr_next = (state_next == TOLR_RUN) && both_on && !alm_next && excite_cmd_i;
      rdy_next = pwr_next;
      drdy_next = pwr_next && !ctrl_reg[`TOLR_CTRL_PULSE];
      prdy_next = pwr_next && ctrl_reg[`TOLR_CTRL_PULSE];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= TOLR_LATCHED;
         mon_reg <= 1'b1;
         pwr_reg <= 1'b0;
         alm_reg <= 1'b0;
         rdy_reg <= 1'b0;
         drdy_reg <= 1'b0;
         prdy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mon_reg <= mon_next;
         pwr_reg <= pwr_next;
         alm_reg <= alm_next;
         rdy_reg <= rdy_next;
         drdy_reg <= drdy_next;
         prdy_reg <= prdy_next;
      end
   end
   // ==========================================
   // Register bus
   logic [3:0] ctrl_next;
   logic [3:0] ist_reg, ist_next;
   logic [3:0] ien_reg, ien_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic irq_reg, irq_next;
   logic wr, rd;
   // Single-cycle ack; the extra term keeps back-to-back strobes from double acking
   always_comb begin
      wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
      rd = wb_cyc_i && wb_stb_i && !ack_reg;
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      ctrl_next = (wr && wb_adr_i == `TOLR_ADR_CTRL) ? wb_dat_i[3:0] : ctrl_reg;
      ien_next = (wr && wb_adr_i == `TOLR_ADR_IRQ_EN) ? wb_dat_i[3:0] : ien_reg;
      // Set wins over clear so no event is lost
      ist_next = ((wr && wb_adr_i == `TOLR_ADR_IRQ_CLR) ? (ist_reg & ~wb_dat_i[3:0]) : ist_reg) | ev;
      irq_next = |(ist_next & ien_next);
      dat_next = 32'h0;
      if (rd) begin
         case (wb_adr_i)
            `TOLR_ADR_CTRL: dat_next = {28'h0, ctrl_reg};
            `TOLR_ADR_STAT: dat_next = {22'h0, state_reg, alm_reg, mon_reg, pwr_reg, rdy_reg, 1'b0,
                                        torque_off_in_b, torque_off_in_a};
            `TOLR_ADR_IRQ_STAT: dat_next = {28'h0, ist_reg};
            `TOLR_ADR_IRQ_EN: dat_next = {28'h0, ien_reg};
            default: dat_next = 32'h0;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `TOLR_CTRL_RST;
         ist_reg <= 4'h0;
         ien_reg <= 4'h0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ist_reg <= ist_next;
         ien_reg <= ien_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         irq_reg <= irq_next;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_o = irq_reg;
   assign shutoff_monitor_out = mon_reg;
   assign motor_power_o = pwr_reg;
   assign alarm_o = alm_reg;
   assign ready_o = rdy_reg;
   assign direct_cmd_ready_out = drdy_reg;
   assign pulse_cmd_ready_out = prdy_reg;
   // ==========================================
   // Checks
   a_both_off_mon: assert property (@(posedge clk_i) disable iff (rst_i)
      (!torque_off_in_a && !torque_off_in_b) |=> (shutoff_monitor_out && !motor_power_o))
      else $error("monitor not raised with both inputs off");
   a_latch_holds_mon: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != TOLR_RUN) |-> shutoff_monitor_out)
      else $error("monitor dropped while latched");
   a_no_release_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != TOLR_RUN && !(torque_off_in_a && torque_off_in_b)) |=> (state_reg != TOLR_RUN))
      else $error("released with an input off");
   a_alarm_mode_src: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == TOLR_ALARM && !eif.rise[`TOLR_SRC_ALARM_CLR]) |=> (state_reg == TOLR_ALARM))
      else $error("alarm shutdown left without alarm clear edge");
   a_latch_mode_sel: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == TOLR_RUN && !torque_off_in_a && !torque_off_in_b)
      |=> (state_reg == (ctrl_reg[`TOLR_CTRL_MODE] ? TOLR_ALARM : TOLR_LATCHED)))
      else $error("wrong shutoff state entered");
   a_one_off_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
      (torque_off_in_a != torque_off_in_b) |=> (alarm_o && !motor_power_o))
      else $error("single input off without alarm");
   a_ready_pair: assert property (@(posedge clk_i) disable iff (rst_i)
      ready_o |-> (direct_cmd_ready_out != pulse_cmd_ready_out) && motor_power_o)
      else $error("ready outputs inconsistent");
   a_release_excite: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg != TOLR_RUN && state_next == TOLR_RUN && excite_cmd_i && !alm_next)
      |=> motor_power_o && ready_o)
      else $error("no excitation on release");
   a_latch_src_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == TOLR_LATCHED && !src_edge) |=> (state_reg == TOLR_LATCHED))
      else $error("latched state left without source edge");
   a_single_release: assert property (@(posedge clk_i) disable iff (rst_i)
      ev[`TOLR_EV_RELEASE] |=> !eif.rise[`TOLR_SRC_SHUTOFF_CLR] && !eif.rise[`TOLR_SRC_ALARM_CLR]
         && !eif.rise[`TOLR_SRC_AUX])
      else $error("edge repeated");
endmodule : tolr_top
`default_nettype wire

// ### bench/tolr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Safety contacts, operator reset lines and the master's excitation command
module tolr_far_model (
   // Clock and feedback
   input wire logic clk_i,
   input wire logic ready_i,
   // Lines into the drive
   output logic to_a_o,
   output logic to_b_o,
   output logic [2:0] rs_o,
   output logic excite_o
);
   // ==========================================
   // Line state
   // Contacts start closed, as with the factory jumper; excitation requested until withdrawn
   initial begin
      to_a_o = 1'b1;
      to_b_o = 1'b1;
      rs_o = 3'h0;
      excite_o = 1'b1;
   end
   // Open or close the two contacts, then let the drive settle
   task contacts(input logic a, input logic b);
      @(posedge clk_i);
      to_a_o <= a;
      to_b_o <= b;
      repeat (3) @(posedge clk_i);
   endtask : contacts
   // Hold a reset line on until ready shows, then release it; a refused press stays on
   task press(input int idx);
      int k;
      k = 0;
      @(posedge clk_i);
      rs_o[idx] <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (ready_i !== 1'b1 && k < 8);
      if (ready_i === 1'b1) rs_o[idx] <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : press
   // Raise or withdraw the master's excitation command
   task excite(input logic v);
      @(posedge clk_i);
      excite_o <= v;
   endtask : excite
   // Drop every reset line
   task let_go;
      @(posedge clk_i);
      rs_o <= 3'h0;
      repeat (2) @(posedge clk_i);
   endtask : let_go
endmodule : tolr_far_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tolr_consts.svh"
module tb_top;
   logic clk_i, rst_i, cyc, stb, we;
   logic [3:0] adr, sel;
   logic [3:0] bsel = 4'hf;
   logic [31:0] dat, q, dat_o;
   logic ack, a, b, exc, mon, pwr, alm, rdy, dir, pls, irq;
   logic [2:0] rs;
   int fails = 0;
   int n_checks = 0;
   // Rows: source[4:3], pulse op[2], expected direct ready[1], pulse ready[0]
   logic [4:0] rows [3] = '{5'b00010, 5'b01010, 5'b10101};
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      {cyc, stb, we, adr, dat, sel} = '0;
      rst_i = 1'b1;
   end
   tolr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .torque_off_in_a(a), .torque_off_in_b(b), .shutoff_clear_in(rs[0]), .alarm_clear_in(rs[1]),
      .aux_reset_in(rs[2]), .excite_cmd_i(exc), .shutoff_monitor_out(mon), .motor_power_o(pwr),
      .alarm_o(alm), .ready_o(rdy), .direct_cmd_ready_out(dir), .pulse_cmd_ready_out(pls), .irq_o(irq));
   tolr_far_model far (.clk_i(clk_i), .ready_i(rdy), .to_a_o(a), .to_b_o(b), .rs_o(rs), .excite_o(exc));
   // ==========================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Classic single cycle; held until ack is sampled, data taken at that edge
   task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, ad, d, bsel};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      // A missing acknowledge counts against the run
      if (ack !== 1'b1) fails++;
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask : bus
   task end_of_test;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("reset monitor", 1, mon);
      bus(0, `TOLR_ADR_STAT, 0);
      chk("reset stat", 32'h123, q);
      bus(0, 4'hf, 0);
      chk("unmapped", 0, q);
      // A write without the low byte lane selected must leave control untouched
      bsel = 4'h0;
      bus(1, `TOLR_ADR_CTRL, 32'h1);
      bsel = 4'hf;
      bus(0, `TOLR_ADR_CTRL, 0);
      chk("sel0 write", 0, q);
      // Release through each reset source in latch mode, with excitation present
      foreach (rows[i]) begin
         bus(1, `TOLR_ADR_CTRL, {28'h0, rows[i][2], rows[i][4:3], 1'b0});
         far.contacts(0, 0);
         chk("latch mon", 1, mon);
         bus(0, `TOLR_ADR_STAT, 0);
         chk("latch stat", 32'h120, q);
         far.contacts(1, 1);
         chk("held mon", 2'b10, {mon, pwr});
         far.press(rows[i][4:3]);
         chk("rel pwr", 1, pwr);
         chk("rel rdy", {1'b1, rows[i][1:0]}, {rdy, dir, pls});
         bus(0, `TOLR_ADR_STAT, 0);
         chk("rel stat", 32'h9b, q);
      end
      // Reset edge while contacts are open is dropped and, held on, never releases later
      bus(1, `TOLR_ADR_CTRL, 32'h0);
      bus(1, `TOLR_ADR_IRQ_CLR, 32'hf);
      far.contacts(0, 0);
      far.press(0);
      far.contacts(1, 1);
      chk("drop mon", 1, mon);
      chk("no edge", 0, rdy);
      bus(0, `TOLR_ADR_IRQ_STAT, 0);
      chk("drop ev", 1, q[`TOLR_EV_DROPPED]);
      far.let_go();
      far.press(0);
      chk("late rel", 1, rdy);
      // One contact open raises the circuit alarm; cleared before any further release
      far.contacts(1, 0);
      chk("one off", 2'b10, {alm, pwr});
      far.contacts(1, 1);
      far.press(1);
      chk("alm clr", 0, alm);
      // Alarm-shutdown mode leaves only on the alarm clear edge
      bus(1, `TOLR_ADR_CTRL, 32'h1);
      far.contacts(0, 0);
      bus(0, `TOLR_ADR_STAT, 0);
      chk("shut stat", 32'h220, q);
      far.contacts(1, 1);
      far.press(0);
      chk("clr ignored", 1, mon);
      far.let_go();
      far.press(1);
      chk("alm rel", 2'b01, {mon, rdy});
      // Release without excitation leaves the motor off until the command arrives
      bus(1, `TOLR_ADR_CTRL, 32'h0);
      far.contacts(0, 0);
      far.excite(0);
      far.contacts(1, 1);
      far.press(0);
      chk("rel no exc", 0, {mon, pwr, rdy});
      far.excite(1);
      repeat (2) @(posedge clk_i);
      chk("late exc", 2'b11, {pwr, rdy});
      far.let_go();
      // Interrupt: raised, masked, cleared
      bus(1, `TOLR_ADR_CTRL, 32'h0);
      bus(1, `TOLR_ADR_IRQ_CLR, 32'hf);
      bus(1, `TOLR_ADR_IRQ_EN, 32'h1);
      far.contacts(0, 0);
      chk("irq on", 1, irq);
      bus(1, `TOLR_ADR_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("irq mask", 0, irq);
      bus(1, `TOLR_ADR_IRQ_EN, 32'h1);
      bus(1, `TOLR_ADR_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk_i);
      chk("irq clr", 0, irq);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
